// ### scic_ctrl.sv
// Purpose: APB register bank for smart card pin, clock and interrupt control.
// Assumes: All inputs synchronous to clk; the card UART supplies events.
// Notes: Outputs are registered; pullups and power are plain level outputs.
//   The character UART sits outside and takes the timing bundle.
//   Events arrive from the UART and the supply monitor as levels.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module scic_ctrl
  import scic_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Card side pins.
  input wire logic card_detect_pin,
  input wire logic card_reset_pin_in,
  input wire logic card_io_pin,
  input wire logic guard_period_end,
  output logic card_clock_pin,
  output logic card_reset_pin,
  output logic interface_power_enable,
  output logic io_pullup_enable,
  output logic detect_pullup_enable,
  // UART side.
  input wire scic_evt_t events,
  output scic_timing_t timing,
  output logic card_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  // Each register is one aligned word; only byte lane zero holds data.
  // The upper bits of a read are always zero.
  // Pin control holds clock source, manual clock level, reset level and
  // power enable. The data pin bit is read only and shows the pin.
  // Clock config holds divider, half rate, clock enable, repeat select
  // and both pull-up enables. It stays reachable with the clock stopped.
  // Time unit, guard time and wait time are split into byte registers.
  // Guard time has a working copy that moves only at a period end.
  // The pending register clears on read and refuses writes.
  logic [7:0] pin_ctrl_ff, nxt_pin_ctrl;
  logic [7:0] clk_cfg_ff, nxt_clk_cfg;
  logic comp_ff, nxt_comp;
  logic [10:0] etu_ff, nxt_etu;
  logic [8:0] gt_ff, nxt_gt;
  logic [8:0] gt_act_ff, nxt_gt_act;
  logic [23:0] wt_ff, nxt_wt;
  logic [7:0] irq_en_ff, nxt_irq_en;
  logic [7:0] pend_ff, nxt_pend;
  logic etu_reload_ff, nxt_etu_reload;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [1:0] div_cnt_ff, nxt_div_cnt;
  logic base_tick_ff, nxt_base_tick;
  logic half_ff, nxt_half;
  logic gen_clk_ff, nxt_gen_clk;
  logic clk_pin_ff, nxt_clk_pin;
  logic irq_ff, nxt_irq;
  logic [7:0] evt_vec;
  logic wr, rd, card_present, clk_en;
  logic [1:0] div_limit;
  logic [7:0] wb;
  // Derived timing fields, registered for the UART.
  logic [11:0] etu_cnt_ff, nxt_etu_cnt;
  logic [2:0] rep_ff, nxt_rep;

  // Presence is the raw detect pin, synchronous to clk by assumption.
  // It is used whatever the clock enable says, so removal acts at once.
  // The event vector follows the pending bit order; bit six is unused.
  assign card_present = card_detect_pin;
  assign clk_en = clk_cfg_ff[CC_EN];
  assign wb = pwdata[7:0];
  // Only the access phase of an APB transfer takes effect.
  assign wr = psel && penable && pwrite && !pready_ff;
  assign rd = psel && penable && !pwrite && !pready_ff;
  assign evt_vec = {events.tx_empty, 1'b0, events.overload, events.volt_err,
                    events.wait_underflow, events.tx_done, events.rx_done,
                    events.parity_err};

  ////////////////////////////////////////////////////////////////////////////
  // Register write, read and pending logic.
  // A transfer is taken on the edge where select and enable are high
  // and no answer is out; ready, read data and error follow one cycle
  // later, so each access has one wait state.
  // Ready is a one-cycle pulse, so a held access phase is taken once.
  // With the clock stopped every register but clock config answers
  // with an error and keeps its value. Unmapped offsets also error.
  // Power enable clears whenever no card is seen, whatever was written.
  // A pending flag sets in any cycle with its event and enable high.
  // A pending read returns the old flags and clears them, but an event
  // in the same cycle keeps its flag, so no event is lost.
  always_comb begin
    logic blocked;
    blocked = 1'b0;
    nxt_pin_ctrl = pin_ctrl_ff;
    nxt_clk_cfg = clk_cfg_ff;
    nxt_comp = comp_ff;
    nxt_etu = etu_ff;
    nxt_gt = gt_ff;
    nxt_wt = wt_ff;
    nxt_irq_en = irq_en_ff;
    nxt_etu_reload = 1'b0;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_pend = pend_ff;
    // Clock config stays reachable so software can restart the clock.
    blocked = !clk_en && (paddr != ADDR_CLK_CFG);
    // Taking a transfer raises ready for one cycle.
    if (psel && penable && !pready_ff) begin
      nxt_pready = 1'b1;
      nxt_pslverr = blocked;
    end
    // Writes land in the register that the offset selects.
    if (wr && !blocked) begin
      unique case (paddr)
        ADDR_PIN_CTRL: nxt_pin_ctrl = wb & PC_WMASK;
        ADDR_CLK_CFG: nxt_clk_cfg = wb & CC_WMASK;
        ADDR_ETU_HI: begin
          nxt_comp = wb[ETU_COMP];
          nxt_etu = {wb[2:0], etu_ff[7:0]};
          nxt_etu_reload = 1'b1;
        end
        ADDR_ETU_LO: nxt_etu = {etu_ff[10:8], wb};
        ADDR_GT_HI: nxt_gt = {wb[0], gt_ff[7:0]};
        ADDR_GT_LO: nxt_gt = {gt_ff[8], wb};
        ADDR_WT_HI: nxt_wt = {wb, wt_ff[15:0]};
        ADDR_WT_MID: nxt_wt = {wt_ff[23:16], wb, wt_ff[7:0]};
        ADDR_WT_LO: nxt_wt = {wt_ff[23:8], wb};
        ADDR_IRQ_EN: nxt_irq_en = wb & IRQ_MASK;
        default: nxt_pslverr = 1'b1;
      endcase
    end
    // Power enable cannot be set without a card and drops when it leaves.
    if (!card_present) begin
      nxt_pin_ctrl[PC_PWR] = 1'b0;
    end
    // Read data is built only for reads and holds otherwise.
    if (rd) begin
      nxt_prdata = 32'h00000000;
      if (!blocked) begin
        unique case (paddr)
          ADDR_PIN_CTRL: begin
            nxt_prdata[7:0] = pin_ctrl_ff;
            nxt_prdata[PC_RST] = card_reset_pin_in;
            nxt_prdata[PC_IO] = card_io_pin;
          end
          ADDR_CLK_CFG: nxt_prdata[7:0] = clk_cfg_ff;
          ADDR_ETU_HI: nxt_prdata[7:0] = {comp_ff, 4'h0, etu_ff[10:8]};
          ADDR_ETU_LO: nxt_prdata[7:0] = etu_ff[7:0];
          ADDR_GT_HI: nxt_prdata[7:0] = {7'h00, gt_ff[8]};
          ADDR_GT_LO: nxt_prdata[7:0] = gt_ff[7:0];
          ADDR_WT_HI: nxt_prdata[7:0] = wt_ff[23:16];
          ADDR_WT_MID: nxt_prdata[7:0] = wt_ff[15:8];
          ADDR_WT_LO: nxt_prdata[7:0] = wt_ff[7:0];
          ADDR_IRQ_EN: nxt_prdata[7:0] = irq_en_ff;
          ADDR_IRQ_PEND: begin
            nxt_prdata[7:0] = pend_ff;
            nxt_pend = 8'h00;
          end
          default: nxt_pslverr = 1'b1;
        endcase
      end
    end
    // Enabled events set pending flags; a set wins over the read clear.
    nxt_pend = nxt_pend | (evt_vec & irq_en_ff & IRQ_MASK);
    // The request is the OR of next cycle's flags, registered, so it
    // rises with the first flag and drops with the last one.
    nxt_irq = |nxt_pend;
  end

  // Registers the bank state; reset gives the power-on values.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_ctrl_ff <= 8'h00;
      clk_cfg_ff <= RST_CLK_CFG;
      comp_ff <= 1'b0;
      etu_ff <= RST_ETU;
      gt_ff <= RST_GT;
      wt_ff <= RST_WT;
      irq_en_ff <= 8'h00;
      pend_ff <= 8'h00;
      etu_reload_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      pin_ctrl_ff <= nxt_pin_ctrl;
      clk_cfg_ff <= nxt_clk_cfg;
      comp_ff <= nxt_comp;
      etu_ff <= nxt_etu;
      gt_ff <= nxt_gt;
      wt_ff <= nxt_wt;
      irq_en_ff <= nxt_irq_en;
      pend_ff <= nxt_pend;
      etu_reload_ff <= nxt_etu_reload;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Guard time shadow loads only at the end of a guard period.
  // Software may rewrite both bytes at any time; the UART keeps the
  // working copy until it reports that the running period ended.
  // The end pulse is one cycle wide, so the copy is taken once.
  always_comb begin
    nxt_gt_act = gt_act_ff;
    if (guard_period_end) begin
      nxt_gt_act = gt_ff;
    end
  end

  // Registers the working guard time.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gt_act_ff <= RST_GT;
    end else begin
      gt_act_ff <= nxt_gt_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Card clock divider and pin multiplexer.
  // The divider gives a one-cycle base tick every one to four cycles.
  // The generated clock toggles on each tick, or every second tick at
  // half rate, so it is a plain divided clock with no gating.
  // Clearing the clock enable clears the divider and parks the clock
  // low, so the card sees a stopped clock at a known level.
  // In manual mode the pin follows the stored level bit; software sets
  // that bit before leaving generated mode to avoid a glitch.
  // The pin multiplexer is registered, so a change shows a cycle later.
  always_comb begin
    // The divider select picks the last count of the tick counter.
    unique case (clk_cfg_ff[CC_DIV_HI -: 2])
      DIV_BY2: div_limit = 2'h1;
      DIV_BY3: div_limit = 2'h2;
      DIV_BY1: div_limit = 2'h0;
      DIV_BY4: div_limit = 2'h3;
    endcase
    nxt_div_cnt = div_cnt_ff;
    nxt_base_tick = 1'b0;
    nxt_half = half_ff;
    nxt_gen_clk = gen_clk_ff;
    if (clk_en) begin
      if (div_cnt_ff >= div_limit) begin
        nxt_div_cnt = 2'h0;
        nxt_base_tick = 1'b1;
      end else begin
        nxt_div_cnt = div_cnt_ff + 2'h1;
      end
      // Card clock toggles on each base tick, or every second one when halved.
      if (base_tick_ff) begin
        nxt_half = !half_ff;
        if (!clk_cfg_ff[CC_HALF] || half_ff) begin
          nxt_gen_clk = !gen_clk_ff;
        end
      end
    end else begin
      nxt_div_cnt = 2'h0;
      nxt_half = 1'b0;
      nxt_gen_clk = 1'b0;
    end
    // The pin takes the generated clock or the stored level bit.
    if (pin_ctrl_ff[PC_SRC]) begin
      nxt_clk_pin = gen_clk_ff;
    end else begin
      nxt_clk_pin = pin_ctrl_ff[PC_CLK];
    end
  end

  // Registers the divider, the generated clock and the pin.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_ff <= 2'h0;
      base_tick_ff <= 1'b0;
      half_ff <= 1'b0;
      gen_clk_ff <= 1'b0;
      clk_pin_ff <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      base_tick_ff <= nxt_base_tick;
      half_ff <= nxt_half;
      gen_clk_ff <= nxt_gen_clk;
      clk_pin_ff <= nxt_clk_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing fields derived for the card UART.
  // They are built from next-state values, so they change on the same
  // edge as the register that software wrote, and a read-back never
  // runs ahead of the count that the UART uses.
  // A stored time unit of zero means the longest count, one beyond the
  // eleven-bit field; the extra count bit carries it.
  // Zero is a legal setting, so no error is raised for it.
  always_comb begin
    nxt_etu_cnt = {1'b0, nxt_etu};
    if (nxt_etu == 11'h000) begin
      nxt_etu_cnt = ETU_ZERO_COUNT;
    end
    nxt_rep = 3'h4;
    if (nxt_clk_cfg[CC_REP]) begin
      nxt_rep = 3'h5;
    end
  end

  // Registers the derived timing fields.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      etu_cnt_ff <= {1'b0, RST_ETU};
      rep_ff <= 3'h4;
    end else begin
      etu_cnt_ff <= nxt_etu_cnt;
      rep_ff <= nxt_rep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  // Every output is a flip-flop or a field of one, with no logic after.
  // Reset pin and power enable come straight from pin control, so they
  // move on the edge that takes the write.
  // The pull-up enables are plain levels for the pad cells.
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign card_clock_pin = clk_pin_ff;
  assign card_reset_pin = pin_ctrl_ff[PC_RST];
  assign interface_power_enable = pin_ctrl_ff[PC_PWR];
  assign io_pullup_enable = clk_cfg_ff[CC_PUIO];
  assign detect_pullup_enable = clk_cfg_ff[CC_PUDET];
  assign card_irq = irq_ff;
  assign timing.etu_count = etu_cnt_ff;
  assign timing.etu_comp = comp_ff;
  assign timing.etu_reload = etu_reload_ff;
  assign timing.guard_time = gt_act_ff;
  assign timing.wait_time = wt_ff;
  assign timing.repeat_count = rep_ff;

endmodule : scic_ctrl

// ### scic_pkg.sv
// Purpose: Constants and types for the smart card interface control register bank.
// Assumes: APB with 32-bit data; one register per aligned word.
// Notes: Offsets are byte addresses.
package scic_pkg;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLK_CFG = 8'h04;
  localparam logic [7:0] ADDR_ETU_HI = 8'h08;
  localparam logic [7:0] ADDR_ETU_LO = 8'h0c;
  localparam logic [7:0] ADDR_GT_HI = 8'h10;
  localparam logic [7:0] ADDR_GT_LO = 8'h14;
  localparam logic [7:0] ADDR_WT_HI = 8'h18;
  localparam logic [7:0] ADDR_WT_MID = 8'h1c;
  localparam logic [7:0] ADDR_WT_LO = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h24;
  localparam logic [7:0] ADDR_IRQ_PEND = 8'h28;
  // Pin control field positions.
  localparam int PC_SRC = 7;
  localparam int PC_IO = 3;
  localparam int PC_CLK = 2;
  localparam int PC_RST = 1;
  localparam int PC_PWR = 0;
  // Clock config field positions.
  localparam int CC_DIV_HI = 7;
  localparam int CC_HALF = 5;
  localparam int CC_EN = 4;
  localparam int CC_REP = 2;
  localparam int CC_PUIO = 1;
  localparam int CC_PUDET = 0;
  localparam int ETU_COMP = 7;
  // Writable masks and reset values.
  localparam logic [7:0] PC_WMASK = 8'h87;
  localparam logic [7:0] CC_WMASK = 8'hf7;
  localparam logic [7:0] IRQ_MASK = 8'hbf;
  localparam logic [7:0] RST_CLK_CFG = 8'h00;
  localparam logic [10:0] RST_ETU = 11'h174;
  localparam logic [8:0] RST_GT = 9'h00c;
  localparam logic [23:0] RST_WT = 24'h000000;
  localparam logic [11:0] ETU_ZERO_COUNT = 12'h800;
  // Divider codes.
  localparam logic [1:0] DIV_BY2 = 2'h0;
  localparam logic [1:0] DIV_BY3 = 2'h1;
  localparam logic [1:0] DIV_BY1 = 2'h2;
  localparam logic [1:0] DIV_BY4 = 2'h3;
  // Pending bit positions.
  localparam int IR_TXE = 7;
  localparam int IR_OVL = 5;
  localparam int IR_VOLT = 4;
  localparam int IR_WT = 3;
  localparam int IR_TXC = 2;
  localparam int IR_RXC = 1;
  localparam int IR_PAR = 0;

  // Events from the card UART and the supply monitor.
  typedef struct packed {
    logic tx_empty;
    logic overload;
    logic volt_err;
    logic wait_underflow;
    logic tx_done;
    logic rx_done;
    logic parity_err;
  } scic_evt_t;

  // Timing settings handed to the card UART.
  typedef struct packed {
    logic [11:0] etu_count;
    logic etu_comp;
    logic etu_reload;
    logic [8:0] guard_time;
    logic [23:0] wait_time;
    logic [2:0] repeat_count;
  } scic_timing_t;
endpackage : scic_pkg

// ### scic_ctrl_checker.sv
// Purpose: Port level assertions for the card control register bank.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Ports are grouped to keep the file short.
`timescale 1ns/1ps
module scic_ctrl_checker
  import scic_pkg::*;
(
  // Clock, reset and APB.
  input wire logic clk, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Card pins.
  input wire logic card_detect_pin, card_reset_pin_in, card_io_pin, guard_period_end,
  input wire logic card_clock_pin, card_reset_pin, interface_power_enable,
  input wire logic io_pullup_enable, detect_pullup_enable, card_irq,
  // UART side.
  input wire scic_evt_t events,
  input wire scic_timing_t timing
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ev_any;
  logic wr_ok;
  // Helpers: any event, and an accepted write at its answer cycle.
  assign ev_any = |events;
  assign wr_ok = pready && !pslverr && pwrite;
  property p_man_clk;
    wr_ok && paddr == ADDR_PIN_CTRL && !pwdata[PC_SRC] |=> card_clock_pin == $past(pwdata[PC_CLK]);
  endproperty
  a_man_clk: assert property (p_man_clk) else $error("manual card clock wrong");
  property p_rst_pin;
    wr_ok && paddr == ADDR_PIN_CTRL |=> card_reset_pin == $past(pwdata[PC_RST]);
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("card reset pin wrong");
  property p_no_card;
    !card_detect_pin [*3] |-> !interface_power_enable;
  endproperty
  a_no_card: assert property (p_no_card) else $error("power on without card");
  property p_rep;
    timing.repeat_count inside {3'h4, 3'h5};
  endproperty
  a_rep: assert property (p_rep) else $error("repeat count out of set");
  property p_pull;
    wr_ok && paddr == ADDR_CLK_CFG |=> io_pullup_enable == $past(pwdata[CC_PUIO])
      && detect_pullup_enable == $past(pwdata[CC_PUDET]);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up enables wrong");
  property p_etu;
    timing.etu_count != 12'h000 && timing.etu_count <= ETU_ZERO_COUNT;
  endproperty
  a_etu: assert property (p_etu) else $error("time unit count out of range");
  property p_reload;
    wr_ok && paddr == ADDR_ETU_HI |-> ##[0:2] timing.etu_reload;
  endproperty
  a_reload: assert property (p_reload) else $error("no time unit reload");
  property p_guard;
    $changed(timing.guard_time) |-> $past(guard_period_end);
  endproperty
  a_guard: assert property (p_guard) else $error("guard time changed early");
  property p_irq_src;
    $rose(card_irq) |-> $past(ev_any) || $past(ev_any, 2);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("interrupt without event");
  property p_irq_clr;
    pready && !pslverr && !pwrite && paddr == ADDR_IRQ_PEND && !ev_any && !$past(ev_any)
      ##1 !ev_any |=> !card_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt stuck after read");
endmodule : scic_ctrl_checker

bind scic_ctrl scic_ctrl_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .card_detect_pin(card_detect_pin),
  .card_reset_pin_in(card_reset_pin_in), .card_io_pin(card_io_pin),
  .guard_period_end(guard_period_end), .card_clock_pin(card_clock_pin),
  .card_reset_pin(card_reset_pin), .interface_power_enable(interface_power_enable),
  .io_pullup_enable(io_pullup_enable), .detect_pullup_enable(detect_pullup_enable),
  .card_irq(card_irq), .events(events), .timing(timing));

// ### scic_card_model.sv
// Purpose: Behavioural contact card on the pin side.
// Assumes: Detect pin reads high while a card sits in the slot.
// Notes: The card never drives data; the line is only pulled or floating.
`timescale 1ns/1ps
module scic_card_model (
  // Clock, slot state and pins from the bank.
  input wire logic clk, present, card_reset_pin, io_pullup_enable,
  // Pins seen by the bank.
  output logic card_detect_pin, card_reset_pin_in, card_io_pin
);
  logic pat = 1'b0;
  // A floating data line shows a level that changes every cycle.
  always @(posedge clk) pat <= ~pat;
  assign card_detect_pin = present;
  assign card_reset_pin_in = card_reset_pin;
  assign card_io_pin = io_pullup_enable ? 1'b1 : pat;
endmodule : scic_card_model

// ### test_smart_card_interface_control.sv
// Purpose: Self-checking bench for the card control register bank.
// Assumes: APB answers after one wait state.
// Notes: Register rows first, then pins, clocks and interrupts.
`timescale 1ns/1ps
module test_smart_card_interface_control;
  import scic_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, present, guard_period_end;
  logic [7:0] paddr, rv;
  logic [31:0] pwdata, prdata;
  logic card_detect_pin, card_reset_pin_in, card_io_pin, card_clock_pin, card_reset_pin;
  logic interface_power_enable, io_pullup_enable, detect_pullup_enable, card_irq, ev;
  scic_evt_t events;
  scic_timing_t timing;
  int num_errors = 0, cmp_count = 0, cyc = 0, n;
  int dv[4] = '{2, 3, 1, 4};
  logic [23:0] rows [9] = '{24'h041414, 24'h088585, 24'h0c0000, 24'h100101, 24'h14ffff,
    24'h181212, 24'h1c3434, 24'h205656, 24'h24ffbf};
  scic_ctrl DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .card_detect_pin(card_detect_pin), .card_reset_pin_in(card_reset_pin_in),
    .card_io_pin(card_io_pin), .guard_period_end(guard_period_end),
    .card_clock_pin(card_clock_pin), .card_reset_pin(card_reset_pin),
    .interface_power_enable(interface_power_enable), .io_pullup_enable(io_pullup_enable),
    .detect_pullup_enable(detect_pullup_enable), .events(events), .timing(timing),
    .card_irq(card_irq));
  scic_card_model u_card (.clk(clk), .present(present), .card_reset_pin(card_reset_pin),
    .io_pullup_enable(io_pullup_enable), .card_detect_pin(card_detect_pin),
    .card_reset_pin_in(card_reset_pin_in), .card_io_pin(card_io_pin));
  // Clock and cycle ceiling.
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      stop_test();
    end
  end
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; read data and error land in rv and ev.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    rv = prdata[7:0];
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Counts cycles between two card clock edges, 40 if none.
  task automatic per();
    logic v;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      v = card_clock_pin;
      while (card_clock_pin === v && n < 40) begin
        @(posedge clk);
        n++;
      end
    end
  endtask : per
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // Main sequence.
  initial begin
    clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; guard_period_end = 0; events = '0; present = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("etu", timing.etu_count, 12'h174);
    chk("gt", timing.guard_time, 9'h00c);
    apb(0, 8'h00, 8'h00);
    chk("blocked", ev, 1'b1);
    foreach (rows[i]) begin
      apb(1, rows[i][23:16], rows[i][15:8]);
      apb(0, rows[i][23:16], 8'h00);
      chk("row", rv, rows[i][7:0]);
    end
    chk("etu", timing.etu_count, 12'h500);
    chk("comp", timing.etu_comp, 1'b1);
    chk("wt", timing.wait_time, 24'h123456);
    chk("rep", timing.repeat_count, 3'h5);
    chk("gt", timing.guard_time, 9'h00c);
    guard_period_end <= 1'b1;
    @(posedge clk);
    guard_period_end <= 1'b0;
    repeat (2) @(posedge clk);
    chk("gt", timing.guard_time, 9'h1ff);
    apb(1, 8'h08, 8'h00);
    apb(1, 8'h0c, 8'h00);
    chk("etu0", timing.etu_count, 12'h800);
    apb(0, 8'h2c, 8'h00);
    chk("unmapped", ev, 1'b1);
    apb(1, 8'h00, 8'h01);
    chk("pwr", interface_power_enable, 1'b0);
    present <= 1'b1;
    apb(1, 8'h00, 8'h07);
    repeat (2) @(posedge clk);
    chk("card_clock_pin_level", {card_clock_pin, card_reset_pin, interface_power_enable}, 3'h7);
    apb(0, 8'h00, 8'h00);
    chk("pin", rv & 8'h87, 8'h07);
    apb(1, 8'h04, 8'h04);
    apb(1, 8'h00, 8'h00);
    chk("blocked", {ev, card_reset_pin}, 2'h3);
    present <= 1'b0;
    repeat (3) @(posedge clk);
    chk("pwr", interface_power_enable, 1'b0);
    apb(1, 8'h04, 8'h10);
    apb(1, 8'h00, 8'h80);
    for (int c = 0; c < 8; c++) begin
      apb(1, 8'h04, {c[2:1], c[0], 5'h10});
      per();
      per();
      chk("period", n, dv[c / 2] << (c % 2));
    end
    apb(1, 8'h04, 8'h00);
    per();
    chk("stopped", n, 40);
    apb(1, 8'h04, 8'h13);
    apb(0, 8'h00, 8'h00);
    chk("io", rv[3], 1'b1);
    chk("pull", {io_pullup_enable, detect_pullup_enable}, 2'h3);
    apb(1, 8'h24, 8'h00);
    events <= '1;
    @(posedge clk);
    events <= '0;
    apb(0, 8'h28, 8'h00);
    chk("masked", rv, 8'h00);
    apb(1, 8'h24, 8'hbf);
    for (int k = 0; k < 7; k++) begin
      events <= scic_evt_t'(7'h01 << k);
      @(posedge clk);
      events <= '0;
      repeat (3) @(posedge clk);
      chk("irq", card_irq, 1'b1);
      apb(0, 8'h28, 8'h00);
      chk("pend", rv, (k == 6) ? 8'h80 : 8'h01 << k);
      apb(0, 8'h28, 8'h00);
      chk("clear", {rv, card_irq}, 9'h000);
    end
    // A reset in mid-run returns the bank to its power-on state.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset", {card_irq, card_clock_pin, timing.guard_time}, 11'h00c);
    chk("rep", timing.repeat_count, 3'h4);
    apb(0, 8'h00, 8'h00);
    chk("blocked", ev, 1'b1);
    stop_test();
  end
endmodule : test_smart_card_interface_control
